// File: core/osc_settle_counter.sv
// Crystal cycle counter with sticky threshold flags
module osc_settle_counter
  import osc_settle_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  settle_cnt_if.cnt cnt
);
  logic [CNT_W-1:0] count_reg, count_next;
  logic [FLAG_CNT-1:0] flags_reg, flags_next;
  logic done_reg, done_next;
  logic [CNT_W-1:0] limit;

  assign limit = SETTLE_THR[cnt.limitIdx];

  // Count crystal edges from zero, stopping at the selected wait
  always_comb begin
    count_next = count_reg;
    if (cnt.clr) begin
      count_next = '0;
    end else if (cnt.run && cnt.tick && count_reg < limit) begin
      count_next = count_reg + 17'h0_0001;
    end
    done_next = !cnt.clr && (count_next >= limit);
  end

  // Flags fill from the shortest threshold and stay set until cleared
  generate
    for (genvar i = 0; i < FLAG_CNT; i++) begin : g_flag
      always_comb begin
        flags_next[i] = cnt.clr ? 1'b0 : (flags_reg[i] | (count_reg >= SETTLE_THR[i]));
      end
    end
  endgenerate

  // Register the counter state
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      count_reg <= '0;
      flags_reg <= '0;
      done_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      flags_reg <= flags_next;
      done_reg <= done_next;
    end
  end

  assign cnt.flags = flags_reg;
  assign cnt.done = done_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  AST_FLAG_STICKY: assert property ((|flags_reg) && !cnt.clr |=> (flags_reg & $past(flags_reg)) == $past(flags_reg))
    else $error("settle flag dropped without a clear");
  AST_FLAG_ORDER: assert property (flags_reg[4] || flags_reg[3] || flags_reg[2] || flags_reg[1] |-> flags_reg[0])
    else $error("settle flags not filled in order");
  AST_COUNT_LIMIT: assert property (count_reg <= limit || $changed(cnt.limitIdx))
    else $error("settle counter passed the selected wait");
  AST_NO_RUN_NO_COUNT: assert property (!cnt.run && !cnt.clr |=> $stable(count_reg))
    else $error("settle counter moved before oscillation start");
endmodule // osc_settle_counter

// File: core/osc_settle_pkg.sv
// Package with register map, thresholds and mode types of the oscillator settle timer
package osc_settle_pkg;
  // Register addresses and reset values
  localparam logic [15:0] SETTLE_STATUS_ADDR = 16'hFFA3;
  localparam logic [15:0] SETTLE_SELECT_ADDR = 16'hFFA4;
  localparam logic [7:0] SETTLE_STATUS_RST = 8'h00;
  localparam logic [2:0] SETTLE_SELECT_RST = 3'h5;
  // Field layout: select field is bits 2..0, status flags bits 4..0
  localparam int SEL_MSB = 2;
  localparam int FLAG_CNT = 5;
  localparam int CNT_W = 17;
  // Thresholds in crystal cycles, index 0..4 = 2^11, 2^13, 2^14, 2^15, 2^16
  localparam logic [4:0][16:0] SETTLE_THR = {
    17'h1_0000, 17'h0_8000, 17'h0_4000, 17'h0_2000, 17'h0_0800};
  // Legal select codes
  localparam logic [2:0] SEL_2P11 = 3'h1;
  localparam logic [2:0] SEL_2P13 = 3'h2;
  localparam logic [2:0] SEL_2P14 = 3'h3;
  localparam logic [2:0] SEL_2P15 = 3'h4;
  localparam logic [2:0] SEL_2P16 = 3'h5;

  // Source of the CPU clock
  typedef enum logic [1:0] {
    CPU_ON_FAST,
    CPU_ON_CRYSTAL,
    CPU_ON_EXT,
    CPU_ON_SUB
  } cpu_src_t;

  // Standby mode of the CPU
  typedef enum logic [1:0] {
    MODE_RUN,
    MODE_HALT,
    MODE_STOP,
    MODE_SETTLE
  } mode_t;

  // Select code to threshold index; illegal codes fall back to the longest wait
  function automatic logic [2:0] sel_to_idx(input logic [2:0] code);
    logic [2:0] idx;
    idx = 3'h4;
    unique case (code)
      SEL_2P11: idx = 3'h0;
      SEL_2P13: idx = 3'h1;
      SEL_2P14: idx = 3'h2;
      SEL_2P15: idx = 3'h3;
      default: idx = 3'h4;
    endcase
    return idx;
  endfunction
endpackage

// File: core/osc_stabilization_timer.sv
// Oscillator settle timer with status/select registers and standby clock gating
// Summary of operation
// - Status flags set in order and stay set
// - Status register read-only at FFA3, resets zero
// - Status cleared on reset, STOP, stop-control
// - Counter stops at the selected wait time
// - Waiting begins only after oscillation starts
// - Crystal CPU held after STOP until wait
// - Select register at FFA4, resets to 05h
// - Codes 1 to 5 pick 2^11..2^16 cycles
// - HALT entered from any CPU clock source
// - HALT gates the CPU clock off
// - Fast oscillator and a crystal or external CPU source keep running
// - Sub, slow and crystal clocks keep their pre-HALT run state
// - External clock path follows applied input
module osc_stabilization_timer
  import osc_settle_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [15:0] busAddr,
  input wire logic busWrEn,
  input wire logic busRdEn,
  input wire logic [7:0] busWrData,
  output logic [7:0] busRdData,
  input wire logic haltExec,
  input wire logic stopExec,
  input wire logic wakeReq,
  input wire osc_settle_pkg::cpu_src_t cpuSrc,
  input wire logic crystal_clk,
  input wire logic crystalOscStarted,
  input wire logic main_osc_stop_ctl,
  input wire logic subClkReq,
  input wire logic slowClkReq,
  input wire logic extClkApplied,
  output logic cpuClkEn,
  output logic cpuHold,
  output logic internal_fast_clk_on,
  output logic crystal_osc_on,
  output logic ext_clk_on,
  output logic sub_clk_on,
  output logic internal_slow_clk_on
);
  import osc_settle_pkg::*;

  settle_cnt_if cnt ();

  mode_t mode_reg, mode_next;
  logic [SEL_MSB:0] settle_select_reg, settle_select_next;
  logic [7:0] rdData_reg, rdData_next;
  logic crystalPrev_reg;
  logic subHeld_reg, subHeld_next;
  logic slowHeld_reg, slowHeld_next;
  logic crystalHeld_reg, crystalHeld_next;
  logic cpuClkEn_reg, cpuClkEn_next;
  logic cpuHold_reg, cpuHold_next;
  logic fastOn_reg, fastOn_next;
  logic crystalOn_reg, crystalOn_next;
  logic extOn_reg, extOn_next;
  logic subOn_reg, subOn_next;
  logic slowOn_reg, slowOn_next;
  logic stopTake;
  logic settled_2p11_flag, settled_2p13_flag, settled_2p14_flag;
  logic settled_2p15_flag, settled_2p16_flag;
  logic [7:0] settle_status_reg;

  // Standby sequencing; STOP is refused while the CPU runs on the sub clock
  always_comb begin
    mode_next = mode_reg;
    stopTake = 1'b0;
    unique case (mode_reg)
      MODE_RUN: begin
        if (haltExec) begin
          mode_next = MODE_HALT;
        end else if (stopExec && cpuSrc != CPU_ON_SUB) begin
          mode_next = MODE_STOP;
          stopTake = 1'b1;
        end
      end
      MODE_HALT: begin
        if (wakeReq) begin
          mode_next = MODE_RUN;
        end
      end
      MODE_STOP: begin
        if (wakeReq) begin
          mode_next = (cpuSrc == CPU_ON_CRYSTAL) ? MODE_SETTLE : MODE_RUN;
        end
      end
      MODE_SETTLE: begin
        if (cnt.done) begin
          mode_next = MODE_RUN;
        end
      end
    endcase
  end

  // Counter control: the wait counts crystal edges only once oscillation is up
  assign cnt.clr = stopTake || main_osc_stop_ctl;
  assign cnt.run = crystalOscStarted && crystalOn_reg && mode_reg != MODE_STOP;
  assign cnt.tick = crystal_clk && !crystalPrev_reg;
  assign cnt.limitIdx = sel_to_idx(settle_select_reg);

  osc_settle_counter u_counter (
    .clk(clk),
    .sys_rst(sys_rst),
    .cnt(cnt)
  );

  // Status layout: shortest threshold in bit 4, upper bits read zero
  assign settled_2p11_flag = cnt.flags[0];
  assign settled_2p13_flag = cnt.flags[1];
  assign settled_2p14_flag = cnt.flags[2];
  assign settled_2p15_flag = cnt.flags[3];
  assign settled_2p16_flag = cnt.flags[4];
  assign settle_status_reg = {3'h0, settled_2p11_flag, settled_2p13_flag,
    settled_2p14_flag, settled_2p15_flag, settled_2p16_flag};

  // Register bus: select is byte-written; status ignores writes
  always_comb begin
    settle_select_next = settle_select_reg;
    if (busWrEn && busAddr == SETTLE_SELECT_ADDR) begin
      settle_select_next = busWrData[SEL_MSB:0];
    end
    rdData_next = rdData_reg;
    if (busRdEn) begin
      unique case (busAddr)
        SETTLE_STATUS_ADDR: rdData_next = settle_status_reg;
        SETTLE_SELECT_ADDR: rdData_next = {5'h00, settle_select_reg};
        default: rdData_next = 8'h00;
      endcase
    end
  end

  // Clock run states; held copies are frozen while in HALT
  always_comb begin
    subHeld_next = (mode_reg == MODE_HALT) ? subHeld_reg : subClkReq;
    slowHeld_next = (mode_reg == MODE_HALT) ? slowHeld_reg : slowClkReq;
    crystalHeld_next = (mode_reg == MODE_HALT) ? crystalHeld_reg : !main_osc_stop_ctl;
    cpuClkEn_next = (mode_next == MODE_RUN);
    cpuHold_next = (mode_next == MODE_SETTLE);
    fastOn_next = (mode_next != MODE_STOP);
    crystalOn_next = !main_osc_stop_ctl || cpuSrc == CPU_ON_CRYSTAL;
    extOn_next = extClkApplied;
    subOn_next = subClkReq;
    slowOn_next = slowClkReq;
    if (mode_next == MODE_STOP) begin
      crystalOn_next = 1'b0;
    end else if (mode_next == MODE_HALT) begin
      // A crystal or external CPU source cannot stop; sub, slow and crystal keep their pre-HALT state, external follows its input
      crystalOn_next = (cpuSrc == CPU_ON_CRYSTAL) || crystalHeld_next;
      extOn_next = (cpuSrc == CPU_ON_EXT) || extClkApplied;
      subOn_next = subHeld_next;
      slowOn_next = slowHeld_next;
    end
  end

  // Register all control state
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode_reg <= MODE_RUN;
      settle_select_reg <= SETTLE_SELECT_RST;
      rdData_reg <= SETTLE_STATUS_RST;
      crystalPrev_reg <= 1'b0;
      subHeld_reg <= 1'b0;
      slowHeld_reg <= 1'b0;
      crystalHeld_reg <= 1'b0;
      cpuClkEn_reg <= 1'b1;
      cpuHold_reg <= 1'b0;
      fastOn_reg <= 1'b1;
      crystalOn_reg <= 1'b0;
      extOn_reg <= 1'b0;
      subOn_reg <= 1'b0;
      slowOn_reg <= 1'b0;
    end else begin
      mode_reg <= mode_next;
      settle_select_reg <= settle_select_next;
      rdData_reg <= rdData_next;
      crystalPrev_reg <= crystal_clk;
      subHeld_reg <= subHeld_next;
      slowHeld_reg <= slowHeld_next;
      crystalHeld_reg <= crystalHeld_next;
      cpuClkEn_reg <= cpuClkEn_next;
      cpuHold_reg <= cpuHold_next;
      fastOn_reg <= fastOn_next;
      crystalOn_reg <= crystalOn_next;
      extOn_reg <= extOn_next;
      subOn_reg <= subOn_next;
      slowOn_reg <= slowOn_next;
    end
  end

  // Outputs come straight from flops
  assign busRdData = rdData_reg;
  assign cpuClkEn = cpuClkEn_reg;
  assign cpuHold = cpuHold_reg;
  assign internal_fast_clk_on = fastOn_reg;
  assign crystal_osc_on = crystalOn_reg;
  assign ext_clk_on = extOn_reg;
  assign sub_clk_on = subOn_reg;
  assign internal_slow_clk_on = slowOn_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_halt_in;
    mode_reg == MODE_RUN && haltExec;
  endsequence

  sequence s_stop_out_crystal;
    mode_reg == MODE_STOP && wakeReq && cpuSrc == CPU_ON_CRYSTAL;
  endsequence

  AST_HALT_GATES_CPU: assert property (s_halt_in |=> !cpuClkEn ##0 internal_fast_clk_on)
    else $error("CPU clock not gated in HALT");
  AST_STOP_CLEARS_STATUS: assert property (stopTake |=> ##1 settle_status_reg == 8'h00)
    else $error("status not cleared by STOP");
  AST_STATUS_TOP_ZERO: assert property (settle_status_reg[7:5] == 3'h0)
    else $error("status upper bits not zero");
  AST_SELECT_WRITE: assert property (busWrEn && busAddr == SETTLE_SELECT_ADDR ##1 busRdEn
      && busAddr == SETTLE_SELECT_ADDR && !busWrEn |=> busRdData == {5'h00, $past(busWrData[2:0], 2)})
    else $error("select readback mismatch");
  AST_SETTLE_HOLD: assert property (s_stop_out_crystal |=> cpuHold && !cpuClkEn)
    else $error("CPU not held after STOP release on crystal");
  AST_HOLD_UNTIL_DONE: assert property (mode_reg == MODE_SETTLE && !cnt.done |=> cpuHold)
    else $error("CPU released before settle wait");
  AST_HALT_KEEP_SUB: assert property (mode_reg == MODE_HALT && mode_next == MODE_HALT
      |=> $stable(sub_clk_on) && $stable(internal_slow_clk_on))
    else $error("sub or slow clock changed in HALT");
  AST_HALT_CPU_SRC_RUNS: assert property (mode_next == MODE_HALT && cpuSrc == CPU_ON_CRYSTAL
      |=> crystal_osc_on)
    else $error("crystal stopped while it drives the halted CPU");
  AST_HALT_EXT_FOLLOWS: assert property (mode_next == MODE_HALT && cpuSrc == CPU_ON_FAST
      |=> ext_clk_on == $past(extClkApplied))
    else $error("external clock path not following input in HALT");
  AST_STOP_OSC_OFF: assert property (stopTake |=> !internal_fast_clk_on && !crystal_osc_on)
    else $error("oscillators still on in STOP");
endmodule // osc_stabilization_timer

// File: core/settle_cnt_if.sv
// Interface between the standby controller and the settle counter
interface settle_cnt_if;
  logic clr;
  logic run;
  logic tick;
  logic [2:0] limitIdx;
  logic [4:0] flags;
  logic done;
  modport ctl (output clr, output run, output tick, output limitIdx, input flags, input done);
  modport cnt (input clr, input run, input tick, input limitIdx, output flags, output done);
endinterface

// File: testbench/osc_stabilization_timer_tb_top.sv
// Self-checking bench for the oscillator settle timer: registers, STOP settle wait, HALT gating
module osc_stabilization_timer_tb_top;
  import osc_settle_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [15:0] busAddr = 16'h0000;
  logic busWrEn = 1'b0;
  logic busRdEn = 1'b0;
  logic [7:0] busWrData = 8'h00;
  logic [7:0] busRdData;
  logic haltExec = 1'b0;
  logic stopExec = 1'b0;
  logic wakeReq = 1'b0;
  cpu_src_t cpuSrc = CPU_ON_FAST;
  logic crystal_clk = 1'b0;
  logic crystalOscStarted = 1'b0;
  logic main_osc_stop_ctl = 1'b0;
  logic subClkReq = 1'b0;
  logic slowClkReq = 1'b0;
  logic extClkApplied = 1'b0;
  logic cpuClkEn, cpuHold, internal_fast_clk_on, crystal_osc_on;
  logic ext_clk_on, sub_clk_on, internal_slow_clk_on;
  int error_cnt = 0;
  int cmp_count = 0;

  // 200 MHz system clock
  always #2.5 clk = ~clk;

  osc_stabilization_timer dut_u (
    .clk(clk), .sys_rst(sys_rst), .busAddr(busAddr), .busWrEn(busWrEn),
    .busRdEn(busRdEn), .busWrData(busWrData), .busRdData(busRdData),
    .haltExec(haltExec), .stopExec(stopExec), .wakeReq(wakeReq), .cpuSrc(cpuSrc),
    .crystal_clk(crystal_clk), .crystalOscStarted(crystalOscStarted),
    .main_osc_stop_ctl(main_osc_stop_ctl), .subClkReq(subClkReq),
    .slowClkReq(slowClkReq), .extClkApplied(extClkApplied), .cpuClkEn(cpuClkEn),
    .cpuHold(cpuHold), .internal_fast_clk_on(internal_fast_clk_on),
    .crystal_osc_on(crystal_osc_on), .ext_clk_on(ext_clk_on), .sub_clk_on(sub_clk_on),
    .internal_slow_clk_on(internal_slow_clk_on)
  );

  // Compare one value; case inequality so an unknown never matches
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Settle a few edges, then sample past the update of the last one
  task automatic waitc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // One-cycle byte write strobe
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    busAddr <= a;
    busWrData <= d;
    busWrEn <= 1'b1;
    @(posedge clk);
    busWrEn <= 1'b0;
  endtask

  // Read strobe driven at one edge, taken and data registered at the next
  task automatic rd(input logic [15:0] a, input logic [7:0] exp, input string what);
    @(posedge clk);
    busAddr <= a;
    busRdEn <= 1'b1;
    @(posedge clk);
    busRdEn <= 1'b0;
    waitc(1);
    chk(what, busRdData, exp);
  endtask

  // One-cycle standby event pulse: 0 halt, 1 stop, 2 wake
  task automatic evt(input int kind);
    @(posedge clk);
    haltExec <= (kind == 0);
    stopExec <= (kind == 1);
    wakeReq <= (kind == 2);
    @(posedge clk);
    haltExec <= 1'b0;
    stopExec <= 1'b0;
    wakeReq <= 1'b0;
  endtask

  // Crystal edges are sampled as data, so each takes two system cycles
  task automatic crys(input int n);
    repeat (n) begin
      @(posedge clk);
      crystal_clk <= 1'b1;
      @(posedge clk);
      crystal_clk <= 1'b0;
    end
  endtask

  // Single exit point for both the normal end and the watchdog
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Watchdog: the whole sequence needs roughly 38k cycles
  initial begin
    repeat (80000) @(posedge clk);
    error_cnt++;
    finish_test();
  end

  // Main test sequence
  initial begin
    cpu_src_t src;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    // Reset values, read-only status, dropped select bits, unmapped place
    rd(SETTLE_STATUS_ADDR, 8'h00, "status reset");
    rd(SETTLE_SELECT_ADDR, 8'h05, "select reset");
    wr(SETTLE_STATUS_ADDR, 8'hFF);
    rd(SETTLE_STATUS_ADDR, 8'h00, "status write ignored");
    wr(SETTLE_SELECT_ADDR, 8'hFF);
    rd(SETTLE_SELECT_ADDR, 8'h07, "select upper bits");
    wr(16'h1234, 8'hAA);
    rd(16'h1234, 8'h00, "unmapped read");
    // Write then read on the very next edge, as the bus allows back to back
    @(posedge clk);
    busAddr <= SETTLE_SELECT_ADDR;
    busWrData <= 8'h03;
    busWrEn <= 1'b1;
    @(posedge clk);
    busWrEn <= 1'b0;
    busRdEn <= 1'b1;
    @(posedge clk);
    busRdEn <= 1'b0;
    waitc(1);
    chk("select back to back", busRdData, 8'h03);
    // Whole-byte write of a legal code, made before STOP on the crystal CPU
    wr(SETTLE_SELECT_ADDR, 8'h01);
    rd(SETTLE_SELECT_ADDR, 8'h01, "select write");
    // STOP on crystal CPU: held until exactly 2^11 counted edges after oscillation starts
    cpuSrc <= CPU_ON_CRYSTAL;
    evt(1);
    waitc(2);
    chk("stop cpu clock", cpuClkEn, 8'h00);
    evt(2);
    waitc(2);
    chk("settle hold", cpuHold, 8'h01);
    chk("settle cpu clock", cpuClkEn, 8'h00);
    crys(100); // Startup edges before oscillation are not counted
    crystalOscStarted <= 1'b1;
    crys(2047); // Select left alone while the wait runs
    waitc(3);
    chk("hold one short", cpuHold, 8'h01);
    rd(SETTLE_STATUS_ADDR, 8'h00, "status one short");
    crys(1);
    waitc(4);
    chk("hold released", cpuHold, 8'h00);
    chk("cpu clock back", cpuClkEn, 8'h01);
    rd(SETTLE_STATUS_ADDR, 8'h10, "status 2p11");
    // STOP clears status; fast CPU runs at once and the counter stops at the select
    wr(SETTLE_SELECT_ADDR, 8'h02); // Wait 2^13, shorter than the 2^14 the edges would reach
    cpuSrc <= CPU_ON_FAST;
    evt(1);
    rd(SETTLE_STATUS_ADDR, 8'h00, "status cleared by stop");
    evt(2);
    waitc(3);
    chk("fast no hold", cpuHold, 8'h00);
    chk("fast cpu clock", cpuClkEn, 8'h01);
    crys(4000);
    waitc(3);
    rd(SETTLE_STATUS_ADDR, 8'h10, "status partial");
    crys(12500);
    waitc(3);
    rd(SETTLE_STATUS_ADDR, 8'h18, "status capped at select");
    main_osc_stop_ctl <= 1'b1;
    waitc(3);
    rd(SETTLE_STATUS_ADDR, 8'h00, "status cleared by stop control");
    main_osc_stop_ctl <= 1'b0;
    // HALT from every CPU clock source
    subClkReq <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      src = cpu_src_t'(i);
      cpuSrc <= src;
      waitc(2);
      evt(0);
      waitc(2);
      chk("halt cpu clock", cpuClkEn, 8'h00);
      chk("halt fast osc", internal_fast_clk_on, 8'h01);
      chk("halt sub clock", sub_clk_on, 8'h01);
      // A request made during HALT must not start the stopped slow clock
      slowClkReq <= 1'b1;
      waitc(2);
      chk("halt slow kept", internal_slow_clk_on, 8'h00);
      slowClkReq <= 1'b0;
      if (src == CPU_ON_CRYSTAL) begin
        chk("halt crystal src", crystal_osc_on, 8'h01);
      end else if (src == CPU_ON_EXT) begin
        chk("halt ext src", ext_clk_on, 8'h01);
      end else if (src == CPU_ON_FAST) begin
        extClkApplied <= 1'b1;
        waitc(3);
        chk("halt ext applied", ext_clk_on, 8'h01);
        extClkApplied <= 1'b0;
        waitc(3);
        chk("halt ext removed", ext_clk_on, 8'h00);
      end
      evt(2);
      waitc(2);
      chk("wake cpu clock", cpuClkEn, 8'h01);
    end
    finish_test();
  end
endmodule // osc_stabilization_timer_tb_top
